// ===== inc/vca_pkg.sv
/*
 * Constants, register map and types for the channel access transmitter.
 * Assumes a 32-bit APB master and one clock running at the channel bit rate.
 */
package vca_pkg;
	// ==========================================================
	// register map (byte addresses)
	localparam logic [7:0]  A_CTRL    = 8'h00;
	localparam logic [7:0]  A_SCID    = 8'h04;
	localparam logic [7:0]  A_FLEN    = 8'h08;
	localparam logic [7:0]  A_ILEN    = 8'h0C;
	localparam logic [7:0]  A_SYNC    = 8'h10;
	localparam logic [7:0]  A_STAT    = 8'h14;
	localparam logic [7:0]  A_FCNT    = 8'h18;
	// ==========================================================
	// control and status fields
	localparam int          C_RUN     = 0;
	localparam int          C_HEC     = 1;
	localparam int          C_CRC     = 2;
	localparam int          C_RS      = 3;
	localparam int          C_INS     = 4;
	localparam int          C_EXT     = 5;
	localparam int          C_RAND    = 6;
	localparam int          C_EXTF    = 7;
	localparam int          C_REPLAY  = 8;
	localparam int          S_ACTIVE  = 0;
	localparam int          S_CONFL   = 1;
	localparam int          S_INSMISS = 2;
	// ==========================================================
	// reset values
	localparam logic [8:0]  CTRL_RST  = 9'h000;
	localparam logic [7:0]  SCID_RST  = 8'h00;
	localparam logic [15:0] FLEN_RST  = 16'h0040;
	localparam logic [7:0]  ILEN_RST  = 8'h04;
	localparam logic [31:0] SYNC_RST  = 32'hA5A5F00F;
	// ==========================================================
	// frame layout and coding
	localparam logic [1:0]  VER       = 2'b01;
	localparam logic [5:0]  FILL_VCID = 6'h3F;
	localparam logic [7:0]  FILL_BYTE = 8'h55;
	localparam logic [15:0] HDR_LEN   = 16'h0006;
	localparam logic [15:0] HEC_LEN   = 16'h0002;
	localparam logic [15:0] CRC_LEN   = 16'h0002;
	localparam int          RS_N      = 4;
	localparam logic [15:0] RS_LEN    = 16'h0004;
	localparam logic [7:0]  RS_GEN [RS_N] = '{8'h0F, 8'h36, 8'h78, 8'h40};
	localparam logic [7:0]  GF_POLY   = 8'h1D;
	localparam logic [15:0] CRC_POLY  = 16'h1021;
	localparam logic [15:0] CRC_INIT  = 16'hFFFF;
	localparam logic [7:0]  LFSR_INIT = 8'hFF;
	localparam logic [4:0]  SYNC_LAST = 5'h1F;
	localparam int          VC_NUM    = 64;
	// ==========================================================
	// types
	typedef logic [7:0] vca_byte_t;
	typedef enum logic [1:0] {PH_IDLE, PH_SYNC, PH_BODY} vca_phase_e;
	typedef enum logic [1:0] {SRC_FILL, SRC_VC, SRC_EXT} vca_src_e;
endpackage

// ===== rtl/vca_tx.sv
/*
 * Transmit channel access: commutation, fill, header check, trailer CRC,
 * check symbols, insert injection, randomizer and marker delimiting.
 * Assumes APB on clk, frame and insert suppliers on the same clock,
 * and clk equal to the channel bit rate.
 */
// Contract
// RQ1 - one commutator, management-set release order
// RQ2 - fill requested to keep stream continuous
// RQ3 - fill frame channel id all ones
// RQ4 - fill frames need no counter
// RQ5 - optional header check field when enabled
// RQ6 - header check also for grade-1/2 cases
// RQ7 - optional trailer CRC over whole frame
// RQ8 - optional check symbols appended after frame
// RQ9 - fixed frame length; coded data zone shorter
// RQ10 - external frames bypass header check, CRC
// RQ11 - external supplier pre-codes and shortens frames
// RQ12 - insert zone in every frame incl fill
// RQ13 - insert and external service never together
// RQ14 - insert supplier delivers once per frame period
// RQ15 - insert bytes copied octet aligned
// RQ16 - insert placed before CRC and check symbols
// RQ17 - randomize all bits except marker
// RQ18 - randomizer polynomial x8+x7+x5+x3+1
// RQ19 - period 255, reload ones during marker
// RQ20 - first sequence bit on first frame bit
// RQ21 - frames released at rate, commutator order
// RQ22 - marker prefixed, contiguous one CADU per slot
// RQ23 - independent counter per virtual channel
// RQ24 - header version, id, counter, signalling
// RQ25 - static config loaded before transmission
module vca_tx (
	input  wire logic               clk,
	input  wire logic               reset_n,
	input  wire logic               psel,
	input  wire logic               penable,
	input  wire logic               pwrite,
	input  wire logic [7:0]         paddr,
	input  wire logic [31:0]        pwdata,
	output logic                    pready,
	output logic [31:0]             prdata,
	output logic                    pslverr,
	input  wire logic               vc_valid,
	input  wire logic [5:0]         vc_vcid,
	input  wire vca_pkg::vca_byte_t vc_data,
	output logic                    vc_ack,
	input  wire logic               ext_valid,
	input  wire vca_pkg::vca_byte_t ext_data,
	output logic                    ext_ack,
	input  wire logic               ins_valid,
	input  wire vca_pkg::vca_byte_t ins_data,
	output logic                    ins_ack,
	output logic                    tx_bit,
	output logic                    tx_valid,
	output logic                    tx_sof
);
	import vca_pkg::*;

	// ==========================================================
	// state
	logic [8:0]  ctrl_r;
	logic [7:0]  scid_r;
	logic [15:0] flen_r;
	logic [7:0]  ilen_r;
	logic [31:0] sync_r;
	logic        ins_miss_r;
	logic [31:0] fcnt_r;
	logic        pready_r;
	logic [31:0] prdata_r;
	logic        pslverr_r;
	vca_phase_e  phase_r;
	vca_src_e    src_r;
	logic [4:0]  scnt_r;
	logic [2:0]  bcnt_r;
	logic [15:0] idx_r;
	logic [7:0]  sh_r;
	logic [7:0]  lfsr_r;
	logic [31:0] mk_r;
	logic [15:0] hec_r;
	logic [15:0] crc_r;
	logic [5:0]  vcid_r;
	logic [23:0] cnt_r;
	logic        ins_ok_r;
	logic [23:0] vc_cnt_r [VC_NUM];
	logic [7:0]  rs_r [RS_N];
	logic        tx_bit_r;
	logic        tx_valid_r;
	logic        tx_sof_r;
	logic        vc_ack_r;
	logic        ext_ack_r;
	logic        ins_ack_r;

	logic        hec_en;
	logic        crc_en;
	logic        rs_en;
	logic        ins_en;
	logic        ext_en;
	logic        rand_en;
	logic        conflict;
	logic        wr;
	logic        idle;
	logic [15:0] hl;
	logic [15:0] ie;
	logic [15:0] de;
	logic [15:0] te;
	logic        load;
	logic        frame_end;
	logic        slot_start;
	vca_src_e    pick;
	logic        f_ext;
	logic        f_ins;
	logic        f_dat;
	logic        f_crc;
	logic        f_rs;
	logic [47:0] hdr;
	logic [7:0]  nb;
	logic [7:0]  fb;

	function automatic logic [15:0] crc_upd(input logic [15:0] c, input logic [7:0] d);
		logic [15:0] r;
		r = c;
		for (int k = 7; k >= 0; k--) begin
			r = (r[15] ^ d[k]) ? ({r[14:0], 1'b0} ^ CRC_POLY) : {r[14:0], 1'b0};
		end
		return r;
	endfunction

	function automatic logic [7:0] gmul(input logic [7:0] a, input logic [7:0] b);
		logic [7:0] p;
		logic [7:0] x;
		p = 8'h00;
		x = a;
		for (int k = 0; k < 8; k++) begin
			if (b[k]) begin
				p = p ^ x;
			end
			x = x[7] ? ({x[6:0], 1'b0} ^ GF_POLY) : {x[6:0], 1'b0};
		end
		return p;
	endfunction

	// ==========================================================
	// configuration decode and frame geometry
	assign hec_en   = ctrl_r[C_HEC];                         // [RQ5] [RQ6]
	assign crc_en   = ctrl_r[C_CRC];
	assign rs_en    = ctrl_r[C_RS];
	assign ins_en   = ctrl_r[C_INS];
	assign ext_en   = ctrl_r[C_EXT];
	assign rand_en  = ctrl_r[C_RAND];
	assign conflict = ins_en & ext_en;
	assign idle     = (phase_r == PH_IDLE);
	assign hl = hec_en ? HDR_LEN + HEC_LEN : HDR_LEN;
	assign ie = ins_en ? hl + {8'h00, ilen_r} : hl;
	// coded frames keep the slot length, data zone gives way  [RQ9]
	assign de = rs_en ? flen_r - RS_LEN : flen_r;
	assign te = crc_en ? de - CRC_LEN : de;

	// ==========================================================
	// commutation: order set by ext-first bit, fill when nothing waits
	always_comb begin
		if (ctrl_r[C_EXTF] && ext_en && ext_valid) begin  // [RQ1]
			pick = SRC_EXT;
		end else if (vc_valid) begin
			pick = SRC_VC;
		end else if (ext_en && ext_valid) begin
			pick = SRC_EXT;
		end else begin
			pick = SRC_FILL;                                 // [RQ2]
		end
	end

	assign load       = (phase_r == PH_SYNC && scnt_r == SYNC_LAST) ||
	                    (phase_r == PH_BODY && bcnt_r == 3'h7 && idx_r != flen_r);
	assign frame_end  = phase_r == PH_BODY && bcnt_r == 3'h7 && idx_r == flen_r;
	// a new slot opens right behind the last one, so the stream stays contiguous
	assign slot_start = (idle || frame_end) && ctrl_r[C_RUN] && !conflict;  // [RQ13] [RQ21] [RQ22]

	// ==========================================================
	// byte sourcing by position in the frame
	assign f_ext = src_r == SRC_EXT && idx_r < de;
	assign f_ins = src_r != SRC_EXT && idx_r >= hl && idx_r < ie;
	assign f_dat = src_r != SRC_EXT && idx_r >= ie && idx_r < te;
	// external frames skip both header check and trailer CRC  [RQ10]
	assign f_crc = src_r != SRC_EXT && idx_r < te;
	assign f_rs  = idx_r < de;
	assign hdr   = {VER, scid_r, vcid_r, cnt_r, ctrl_r[C_REPLAY], 7'h00};  // [RQ24]

	always_comb begin
		nb = 8'h00;
		if (f_ext) begin
			nb = ext_data;                                   // [RQ10]
		end else if (!f_rs) begin
			nb = rs_r[RS_N-1];                               // [RQ8]
		end else if (idx_r < HDR_LEN) begin
			nb = hdr[8*(3'h5-idx_r[2:0]) +: 8];
		end else if (idx_r < hl) begin
			nb = (idx_r == HDR_LEN) ? hec_r[15:8] : hec_r[7:0];  // [RQ5]
		end else if (f_ins) begin
			nb = ins_ok_r ? ins_data : 8'h00;                // [RQ12] [RQ15]
		end else if (f_dat) begin
			nb = (src_r == SRC_VC) ? vc_data : FILL_BYTE;
		end else begin
			nb = (idx_r == te) ? crc_r[15:8] : crc_r[7:0];   // [RQ7]
		end
	end

	// ==========================================================
	// slot selection and per-channel counters
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			src_r    <= SRC_FILL;
			vcid_r   <= FILL_VCID;
			cnt_r    <= 24'h000000;
			ins_ok_r <= 1'b0;
		end else if (slot_start) begin
			src_r    <= pick;
			vcid_r   <= (pick == SRC_VC) ? vc_vcid : FILL_VCID;            // [RQ3]
			cnt_r    <= (pick == SRC_VC) ? vc_cnt_r[vc_vcid] : 24'h000000; // [RQ4]
			ins_ok_r <= ins_en & ins_valid;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			for (int v = 0; v < VC_NUM; v++) begin
				vc_cnt_r[v] <= 24'h000000;
			end
		end else if (slot_start && pick == SRC_VC) begin
			vc_cnt_r[vc_vcid] <= vc_cnt_r[vc_vcid] + 24'h000001;  // [RQ23]
		end
	end

	// ==========================================================
	// error control: codes run on the assembled bytes, insert included
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			hec_r <= CRC_INIT;
			crc_r <= CRC_INIT;
		end else if (slot_start) begin
			hec_r <= CRC_INIT;
			crc_r <= CRC_INIT;
		end else if (load) begin
			if (src_r != SRC_EXT && idx_r < HDR_LEN) begin
				hec_r <= crc_upd(hec_r, nb);                 // [RQ5]
			end
			if (f_crc) begin
				crc_r <= crc_upd(crc_r, nb);                 // [RQ7] [RQ16]
			end
		end
	end

	assign fb = nb ^ rs_r[RS_N-1];
	for (genvar i = 0; i < RS_N; i++) begin : g_rs
		always_ff @(posedge clk or negedge reset_n) begin
			if (!reset_n) begin
				rs_r[i] <= 8'h00;
			end else if (slot_start) begin
				rs_r[i] <= 8'h00;
			end else if (load && rs_en) begin
				if (f_rs) begin
					rs_r[i] <= ((i == 0) ? 8'h00 : rs_r[(i+RS_N-1)%RS_N]) ^ gmul(fb, RS_GEN[i]);  // [RQ8] [RQ16]
				end else begin
					rs_r[i] <= (i == 0) ? 8'h00 : rs_r[(i+RS_N-1)%RS_N];
				end
			end
		end
	end

	// ==========================================================
	// delimiting sequencer: marker then frame bytes, msb first
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			phase_r <= PH_IDLE;
			scnt_r  <= 5'h00;
			bcnt_r  <= 3'h0;
			idx_r   <= 16'h0000;
			mk_r    <= 32'h00000000;
			sh_r    <= 8'h00;
		end else begin
			case (phase_r)
				PH_SYNC: begin
					mk_r   <= {mk_r[30:0], 1'b0};
					scnt_r <= scnt_r + 5'h01;
					if (scnt_r == SYNC_LAST) begin
						phase_r <= PH_BODY;
						sh_r    <= nb;
						idx_r   <= 16'h0001;
						bcnt_r  <= 3'h0;
					end
				end
				PH_BODY: begin
					bcnt_r <= bcnt_r + 3'h1;
					sh_r   <= {sh_r[6:0], 1'b0};
					if (load) begin
						sh_r  <= nb;
						idx_r <= idx_r + 16'h0001;
					end else if (slot_start) begin
						phase_r <= PH_SYNC;                  // [RQ22]
						scnt_r  <= 5'h00;
						idx_r   <= 16'h0000;
						mk_r    <= sync_r;
					end else if (frame_end) begin
						phase_r <= PH_IDLE;
					end
				end
				PH_IDLE: begin
					if (slot_start) begin
						phase_r <= PH_SYNC;
						scnt_r  <= 5'h00;
						idx_r   <= 16'h0000;
						mk_r    <= sync_r;
					end
				end
				default: phase_r <= PH_IDLE;
			endcase
		end
	end

	// randomizer reloads during each marker, steps once per frame bit
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			lfsr_r <= LFSR_INIT;
		end else if (phase_r != PH_BODY) begin
			lfsr_r <= LFSR_INIT;                                             // [RQ19]
		end else begin
			lfsr_r <= {lfsr_r[0] ^ lfsr_r[3] ^ lfsr_r[5] ^ lfsr_r[7], lfsr_r[7:1]};  // [RQ18]
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			tx_bit_r   <= 1'b0;
			tx_valid_r <= 1'b0;
			tx_sof_r   <= 1'b0;
			vc_ack_r   <= 1'b0;
			ext_ack_r  <= 1'b0;
			ins_ack_r  <= 1'b0;
		end else begin
			if (phase_r == PH_SYNC) begin
				tx_bit_r <= mk_r[31];                        // [RQ17]
			end else if (phase_r == PH_BODY) begin
				tx_bit_r <= sh_r[7] ^ (rand_en & lfsr_r[0]); // [RQ17] [RQ20]
			end else begin
				tx_bit_r <= 1'b0;
			end
			tx_valid_r <= !idle;
			tx_sof_r   <= phase_r == PH_SYNC && scnt_r == 5'h00;
			vc_ack_r   <= load && f_dat && src_r == SRC_VC;
			ext_ack_r  <= load && f_ext;                     // [RQ11]
			ins_ack_r  <= load && f_ins && ins_ok_r;         // [RQ15]
		end
	end

	// ==========================================================
	// APB slave: zero wait, one access-phase cycle
	assign wr = psel && penable && pready_r && pwrite;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			ctrl_r <= CTRL_RST;
			scid_r <= SCID_RST;
			flen_r <= FLEN_RST;
			ilen_r <= ILEN_RST;
			sync_r <= SYNC_RST;
		end else if (wr) begin
			// static settings only move while the link is stopped  [RQ25]
			if (paddr == A_CTRL) begin
				ctrl_r <= idle ? pwdata[8:0] : {ctrl_r[8:1], pwdata[C_RUN]};
			end
			if (idle && paddr == A_SCID) begin
				scid_r <= pwdata[7:0];
			end
			if (idle && paddr == A_FLEN) begin
				flen_r <= pwdata[15:0];
			end
			if (idle && paddr == A_ILEN) begin
				ilen_r <= pwdata[7:0];
			end
			if (idle && paddr == A_SYNC) begin
				sync_r <= pwdata;
			end
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			ins_miss_r <= 1'b0;
			fcnt_r     <= 32'h00000000;
		end else begin
			// a miss in the clearing cycle still sets
			if (slot_start && ins_en && !ins_valid) begin
				ins_miss_r <= 1'b1;
			end else if (wr && paddr == A_STAT && pwdata[S_INSMISS]) begin
				ins_miss_r <= 1'b0;
			end
			if (frame_end) begin
				fcnt_r <= fcnt_r + 32'h00000001;
			end
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			pready_r  <= 1'b0;
			prdata_r  <= 32'h00000000;
			pslverr_r <= 1'b0;
		end else begin
			pready_r  <= psel && !penable;
			pslverr_r <= 1'b0;
			prdata_r  <= 32'h00000000;
			if (psel && !penable) begin
				case (paddr)
					A_CTRL: prdata_r <= {23'h000000, ctrl_r};
					A_SCID: prdata_r <= {24'h000000, scid_r};
					A_FLEN: prdata_r <= {16'h0000, flen_r};
					A_ILEN: prdata_r <= {24'h000000, ilen_r};
					A_SYNC: prdata_r <= sync_r;
					A_STAT: prdata_r <= {29'h00000000, ins_miss_r, conflict, !idle};
					A_FCNT: prdata_r <= fcnt_r;
					default: pslverr_r <= 1'b1;
				endcase
			end
		end
	end

	assign pready   = pready_r;
	assign prdata   = prdata_r;
	assign pslverr  = pslverr_r;
	assign vc_ack   = vc_ack_r;
	assign ext_ack  = ext_ack_r;
	assign ins_ack  = ins_ack_r;
	assign tx_bit   = tx_bit_r;
	assign tx_valid = tx_valid_r;
	assign tx_sof   = tx_sof_r;

	// ==========================================================
	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	property p_fill_vcid;
		load && src_r == SRC_FILL && idx_r == 16'h0001 |-> nb[5:0] == FILL_VCID;
	endproperty
	a_fill_vcid: assert property (p_fill_vcid) else $error("fill vcid not all ones"); // [RQ3]

	property p_no_conflict;
		idle && conflict |=> idle;
	endproperty
	a_no_conflict: assert property (p_no_conflict) else $error("started with insert and external on"); // [RQ13]

	property p_mark_clear;
		phase_r == PH_SYNC |=> tx_bit_r == $past(mk_r[31]);
	endproperty
	a_mark_clear: assert property (p_mark_clear) else $error("marker bit altered"); // [RQ17]

	property p_reload;
		phase_r == PH_SYNC |=> lfsr_r == LFSR_INIT;
	endproperty
	a_reload: assert property (p_reload) else $error("randomizer not reloaded"); // [RQ19]

	property p_first_bit;
		phase_r == PH_SYNC && scnt_r == SYNC_LAST |=> ##1 tx_bit_r == ($past(sh_r[7]) ^ rand_en);
	endproperty
	a_first_bit: assert property (p_first_bit) else $error("first frame bit not combined with one"); // [RQ20]

	property p_hec_pos;
		load && hec_en && src_r != SRC_EXT && idx_r == HDR_LEN |=> sh_r == $past(hec_r[15:8]);
	endproperty
	a_hec_pos: assert property (p_hec_pos) else $error("header check byte misplaced"); // [RQ5]

	property p_ext_pass;
		load && f_ext |=> ext_ack_r && sh_r == $past(ext_data);
	endproperty
	a_ext_pass: assert property (p_ext_pass) else $error("external byte altered"); // [RQ10]

	property p_crc_pos;
		load && crc_en && src_r != SRC_EXT && idx_r == te |=> sh_r == $past(crc_r[15:8]);
	endproperty
	a_crc_pos: assert property (p_crc_pos) else $error("trailer crc misplaced"); // [RQ7]

	property p_vc_count;
		slot_start && pick == SRC_VC |=> vc_cnt_r[$past(vc_vcid)] == $past(vc_cnt_r[vc_vcid]) + 24'h000001;
	endproperty
	a_vc_count: assert property (p_vc_count) else $error("channel counter not advanced"); // [RQ23]

	property p_ins_copy;
		load && f_ins && ins_ok_r |=> ins_ack_r && sh_r == $past(ins_data);
	endproperty
	a_ins_copy: assert property (p_ins_copy) else $error("insert byte not copied"); // [RQ12]

	property p_contig;
		tx_sof_r |-> tx_valid_r [*8];
	endproperty
	a_contig: assert property (p_contig) else $error("stream gap after marker start"); // [RQ22]
endmodule

// ===== tb/vca_phy_model.sv
/*
 * Physical channel side: deframes the serial CADU stream.
 * Assumes one bit a clk while tx_valid, tx_sof on the first marker bit.
 */
module vca_phy_model (
	input  wire logic               clk,
	input  wire logic               reset_n,
	input  wire logic               tx_bit,
	input  wire logic               tx_valid,
	input  wire logic               tx_sof,
	input  wire logic [15:0]        flen,
	output logic [31:0]             marker,
	output vca_pkg::vca_byte_t      rx [64],
	output int                      frames,
	output int                      slot_err
);
	timeunit 1ns;
	timeprecision 1ns;
	import vca_pkg::*;
	int cnt;
	int c;
	int tot;
	assign tot = 32 + 8 * int'(flen);
	assign c = tx_sof ? 0 : cnt;
	// ==========================================================
	// marker, then frame bytes msb first; gaps and short slots counted
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			cnt <= 0;
			frames <= 0;
			slot_err <= 0;
		end else if (tx_valid) begin
			if ((tx_sof && cnt != 0 && cnt != tot) || c >= tot)
				slot_err <= slot_err + 1;
			if (c < 32)
				marker <= {marker[30:0], tx_bit};
			else if (c < tot)
				rx[(c - 32) / 8] <= {rx[(c - 32) / 8][6:0], tx_bit};
			cnt <= c + 1;
			if (c + 1 == tot)
				frames <= frames + 1;
		end else if (cnt != 0 && cnt != tot) begin
			slot_err <= slot_err + 1;
			cnt <= 0;
		end
	end
endmodule

// ===== tb/vca_channel_access_tx_tb_top.sv
/*
 * Self-checking bench for the channel access transmitter.
 * Assumes vca_pkg, vca_tx and vca_phy_model are compiled first.
 */
module vca_channel_access_tx_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import vca_pkg::*;
	localparam int FL = 40;
	logic clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0;
	logic [7:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, q, seed = 32'h0EA6;
	logic pready, pslverr, e, vc_ack, ext_ack, ins_ack, tx_bit, tx_valid, tx_sof;
	logic vc_valid = 0, ext_valid = 0, ins_valid = 0;
	logic [5:0] vc_vcid = 0, vcid;
	vca_byte_t vc_data = 0, ext_data = 0, ins_data = 0, scid;
	vca_byte_t vdat [64], idat [4], ef [64], rx [64];
	logic [31:0] marker;
	logic [23:0] c0;
	bit rp = 0;
	int frames, slot_err, mismatches = 0, n_checks = 0, vi = 0, ei = 0, ii = 0, dz = FL;
	logic [7:0] ra [7] = '{A_CTRL, A_SCID, A_FLEN, A_ILEN, A_SYNC, A_STAT, A_FCNT};
	logic [31:0] rv [7] = '{32'(CTRL_RST), 32'(SCID_RST), 32'(FLEN_RST), 32'(ILEN_RST), SYNC_RST, 0, 0};
	vca_tx i_dut (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
		.vc_valid(vc_valid), .vc_vcid(vc_vcid), .vc_data(vc_data), .vc_ack(vc_ack),
		.ext_valid(ext_valid), .ext_data(ext_data), .ext_ack(ext_ack), .ins_valid(ins_valid),
		.ins_data(ins_data), .ins_ack(ins_ack), .tx_bit(tx_bit), .tx_valid(tx_valid), .tx_sof(tx_sof));
	vca_phy_model i_phy (.clk(clk), .reset_n(reset_n), .tx_bit(tx_bit), .tx_valid(tx_valid),
		.tx_sof(tx_sof), .flen(16'(FL)), .marker(marker), .rx(rx), .frames(frames), .slot_err(slot_err));
	always #5 clk = ~clk;
	// ==========================================================
	// suppliers: next byte after each ack
	always @(posedge clk) begin
		if (vc_ack === 1'b1) vi <= vi + 1;
		if (ext_ack === 1'b1) ei <= ei + 1;
		if (ins_ack === 1'b1) ii <= ii + 1;
		vc_data <= vdat[(vi + int'(vc_ack === 1'b1)) % dz];
		ext_data <= vdat[(ei + int'(ext_ack === 1'b1)) % FL];
		ins_data <= idat[(ii + int'(ins_ack === 1'b1)) % 4];
	end
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic vca_byte_t pn(int k);
		vca_byte_t w = LFSR_INIT;
		for (int n = 0; n < 8 * k; n++)
			w = {w[6:0], w[0] ^ w[2] ^ w[4] ^ w[7]};
		return w;
	endfunction
	function automatic logic [15:0] crc(int n);
		logic [15:0] r = CRC_INIT;
		for (int j = 0; j < n; j++)
			for (int b = 7; b >= 0; b--)
				r = {r[14:0], 1'b0} ^ ((r[15] ^ ef[j][b]) ? CRC_POLY : 16'h0000);
		return r;
	endfunction
	// field multiply, horner form, modulo the field polynomial
	function automatic vca_byte_t gm(vca_byte_t a, vca_byte_t b);
		vca_byte_t p = 8'h00;
		for (int k = 7; k >= 0; k--)
			p = {p[6:0], 1'b0} ^ (p[7] ? GF_POLY : 8'h00) ^ (b[k] ? a : 8'h00);
		return p;
	endfunction
	// systematic check symbols over ef[0..n-1], highest first after the data
	function automatic void rs(int n);
		vca_byte_t p [RS_N];
		vca_byte_t f;
		foreach (p[i]) p[i] = 8'h00;
		for (int j = 0; j < n; j++) begin
			f = ef[j] ^ p[RS_N - 1];
			for (int i = RS_N - 1; i > 0; i--) p[i] = p[i - 1] ^ gm(f, RS_GEN[i]);
			p[0] = gm(f, RS_GEN[0]);
		end
		for (int i = 0; i < RS_N; i++) ef[n + i] = p[RS_N - 1 - i];
	endfunction
	// expected plain frame: header, check, insert, data, trailer
	function automatic void mk(logic [5:0] v, logic [23:0] c, bit h, bit i, bit cr, bit f);
		int n = 8;
		logic [15:0] k;
		ef[0] = {VER, scid[7:2]};
		ef[1] = {scid[1:0], v};
		{ef[2], ef[3], ef[4], ef[5]} = {c, rp, 7'h00};
		k = crc(6);
		{ef[6], ef[7]} = k;
		if (!h) n = 6;
		if (i) for (int j = 0; j < 4; j++) ef[n++] = idat[j];
		dz = FL - n - (cr ? 2 : 0);
		for (int j = 0; j < dz; j++) ef[n++] = f ? FILL_BYTE : vdat[j];
		k = crc(n);
		if (cr) {ef[n], ef[n + 1]} = k;
	endfunction
	task automatic chk(logic [39:0] g, logic [39:0] x);
		n_checks++;
		if (g !== x) begin
			mismatches++;
			$display("Error at %0t: got %h expected %h", $time, g, x);
		end
	endtask
	task automatic cmp(bit r);
		for (int j = 0; j < FL; j++) chk(rx[j], ef[j] ^ (r ? pn(j) : 8'h00));
	endtask
	task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
		int t = 0;
		@(posedge clk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1;
		do begin
			@(posedge clk);
			t++;
		end while (pready !== 1'b1 && t < 50);
		if (pready !== 1'b1) chk(0, 1);
		q = prdata;
		e = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task automatic wait_frame();
		int f = frames;
		int t = 0;
		while (frames == f && t < 2000) begin
			@(posedge clk);
			t++;
		end
		if (t >= 2000) chk(0, 1);
	endtask
	task automatic stop();
		apb(1, A_CTRL, 0);
		for (int t = 0; t < 200 && q[S_ACTIVE] !== 1'b0; t++) apb(0, A_STAT, 0);
		chk(q[S_ACTIVE], 0);
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial begin
		#400000;
		chk(0, 1);
		report_and_stop();
	end
	// ==========================================================
	// tests
	initial begin
		foreach (vdat[j]) vdat[j] = rnd();
		foreach (idat[j]) idat[j] = rnd();
		scid = rnd();
		vcid = rnd() % 63;
		repeat (12) @(posedge clk);
		reset_n <= 1;
		for (int j = 0; j < 7; j++) begin
			apb(0, ra[j], 0);
			chk(q, rv[j]);
		end
		apb(0, 8'h20, 0);
		chk({e, q}, 33'h100000000);
		$display("test registers done");
		apb(1, A_SCID, 32'(scid));
		apb(1, A_FLEN, 32'(FL));
		mk(FILL_VCID, 0, 0, 0, 0, 1);
		apb(1, A_CTRL, (1 << C_RUN) | (1 << C_RAND));
		apb(1, A_SCID, 32'(~scid));
		apb(0, A_SCID, 0);
		chk(q, 32'(scid));
		repeat (2) begin
			wait_frame();
			chk(marker, SYNC_RST);
			chk({rx[0], rx[1], rx[2], rx[3], rx[4]} ^ {ef[0], ef[1], ef[2], ef[3], ef[4]}, 40'hFF480EC09A);
			cmp(1);
		end
		stop();
		$display("test fill done");
		vi = 0;
		ii = 0;
		rp = 1;
		mk(vcid, 0, 1, 1, 1, 0);
		vc_vcid <= vcid;
		vc_valid <= 1;
		ins_valid <= 1;
		apb(1, A_CTRL, (1 << C_RUN) | (1 << C_HEC) | (1 << C_CRC) | (1 << C_INS) | (1 << C_REPLAY));
		wait_frame();
		c0 = 24'h000000;
		mk(vcid, c0, 1, 1, 1, 0);
		cmp(0);
		wait_frame();
		mk(vcid, c0 + 1, 1, 1, 1, 0);
		cmp(0);
		vc_valid <= 0;
		ins_valid <= 0;
		stop();
		apb(1, A_CTRL, (1 << C_RUN) | (1 << C_INS));
		wait_frame();
		apb(0, A_STAT, 0);
		chk(q[S_INSMISS], 1);
		apb(1, A_STAT, 32'(1 << S_INSMISS));
		apb(0, A_STAT, 0);
		chk(q[S_INSMISS], 0);
		stop();
		$display("test channel done");
		apb(1, A_CTRL, (1 << C_RUN) | (1 << C_INS) | (1 << C_EXT));
		repeat (5) @(posedge clk);
		apb(0, A_STAT, 0);
		chk({q[S_CONFL], q[S_ACTIVE], tx_valid}, 3'b100);
		apb(1, A_CTRL, 0);
		$display("test conflict done");
		ei = 0;
		for (int j = 0; j < FL; j++) ef[j] = vdat[j];
		ext_valid <= 1;
		vc_valid <= 1;
		apb(1, A_CTRL, (1 << C_RUN) | (1 << C_HEC) | (1 << C_CRC) | (1 << C_EXT) | (1 << C_EXTF));
		wait_frame();
		cmp(0);
		vc_valid <= 0;
		stop();
		ei = 0;
		rs(FL - int'(RS_LEN));
		apb(1, A_CTRL, (1 << C_RUN) | (1 << C_RS) | (1 << C_EXT));
		wait_frame();
		cmp(0);
		ext_valid <= 0;
		stop();
		chk(slot_err, 0);
		apb(0, A_FCNT, 0);
		chk(q, 32'(frames));
		$display("test external done");
		report_and_stop();
	end
endmodule
